/* logic/vsr_irq_sync.sv */
/*
 * Three-stage synchroniser for the raster interrupt pin with rising edge pulse.
 * Assumes the pin is asynchronous to mclk.
 */
`timescale 1ns/1ps
module vsr_irq_sync
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic irqPin,
	output logic      irqPulse
);
	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic pulse;
	} vsr_sync_s;

	vsr_sync_s cur;
	vsr_sync_s next_cur;

	always_comb
	begin
		next_cur = cur;
		next_cur.s1 = irqPin;
		next_cur.s2 = cur.s1;
		next_cur.s3 = cur.s2;
		next_cur.pulse = 1'b0;
		// A change counts once stages two and three agree
		if (cur.s2 == cur.s3)
		begin
			next_cur.level = cur.s2;
			next_cur.pulse = cur.s2 & ~cur.level;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign irqPulse = cur.pulse;
endmodule // vsr_irq_sync

/* logic/vsr_pkg.sv */
/*
 * Shared constants for the video shadow register refresh block.
 * Assumes an APB slave with 32-bit data; registers take one word at four times their index.
 */
//
// Functional notes
// R1: At refresh, mode shadow bit 7 goes to horizontal control bit 4.
// R2: Mode shadow bit 6 enables split screen between character and bitmap.
// R3: At refresh, mode shadow bit 5 goes to vertical control bit 5.
// R4: Text pointer upper nibble gives screen matrix pointer in character modes.
// R5: Text pointer lower nibble gives character base pointer in character modes.
// R6: Bitmap pointer upper nibble gives screen matrix pointer in bitmap modes.
// R7: Bitmap pointer lower nibble gives bitmap base pointer in bitmap modes.
// R8: Text pointer shadow is never used for bitmap modes.
// R9: Bitmap pointer shadow is never used for character modes.
// R10: Split screen pairs standard character with standard or multicolor bitmap.
// R11: Split screen mode switch happens at the raster interrupt.
// R12: Each interrupt clears mirrored fields and reloads them from shadows.
// R13: Mode shadow value 255 disables refresh, video registers untouched.
// R14: Direct writes to mirrored registers are overwritten at next interrupt.
// R15: Software writes shadows, or disables refresh before writing real registers.
// R16: Memory pointer upper nibble locates screen, lower nibble locates data.
// R17: Bitmap pointer chosen when bitmap is active for the region, else text.
// R18: All mirrored fields change together in one refresh event.

package vsr_pkg;
	localparam int          ADDR_W        = 20;
	// Register indices; byte address is four times the index
	localparam logic [17:0] IDX_MODE      = 18'h000d8;
	localparam logic [17:0] IDX_TEXT_PTR  = 18'h00a2c;
	localparam logic [17:0] IDX_BMAP_PTR  = 18'h00a2d;
	localparam logic [17:0] IDX_VERT_CTRL = 18'h0d011;
	localparam logic [17:0] IDX_HORZ_CTRL = 18'h0d016;
	localparam logic [17:0] IDX_MEM_PTRS  = 18'h0d018;
	localparam logic [17:0] IDX_STATUS    = 18'h00040;
	// Field positions
	localparam int          MODE_MC_BIT   = 7;
	localparam int          MODE_SPLIT_BIT = 6;
	localparam int          MODE_BMAP_BIT = 5;
	localparam int          HORZ_MC_BIT   = 4;
	localparam int          VERT_BMAP_BIT = 5;
	localparam logic [7:0]  MODE_DISABLE  = 8'hff;
	// Reset values
	localparam logic [7:0]  RST_MODE      = 8'h00;
	localparam logic [7:0]  RST_TEXT_PTR  = 8'h00;
	localparam logic [7:0]  RST_BMAP_PTR  = 8'h00;
	localparam logic [7:0]  RST_VIDEO     = 8'h00;

	typedef enum logic [2:0]
	{
		REG_NONE   = 3'b000,
		REG_MODE   = 3'b001,
		REG_TEXT   = 3'b010,
		REG_BMAP   = 3'b011,
		REG_VERT   = 3'b100,
		REG_HORZ   = 3'b101,
		REG_MEM    = 3'b110,
		REG_STATUS = 3'b111
	} vsr_reg_e;
endpackage

/* logic/vsr_refresh.sv */
/*
 * Refresh engine: on an interrupt pulse computes the new mirrored video register values.
 * Assumes the bank applies vertNew, horzNew and memNew in the cycle after load.
 */
`timescale 1ns/1ps
module vsr_refresh
	import vsr_pkg::*;
(
	input wire logic  mclk,
	input wire logic  rst_n,
	vsr_refresh_if.engine rif
);
	typedef struct packed
	{
		logic       load;
		logic [7:0] vert;
		logic [7:0] horz;
		logic [7:0] mem;
		logic       region;
		logic [7:0] count;
	} vsr_engine_s;

	vsr_engine_s cur;
	vsr_engine_s next_cur;

	always_comb
	begin
		logic split;
		logic bmapOn;
		logic mcOn;
		split = 1'b0;
		bmapOn = 1'b0;
		mcOn = 1'b0;
		next_cur = cur;
		next_cur.load = 1'b0;
		if (rif.trigger && rif.modeShadow != MODE_DISABLE) // R13
		begin
			split = rif.modeShadow[MODE_SPLIT_BIT]; // R2
			// Split screen flips region at every interrupt
			next_cur.region = split ? ~cur.region : 1'b0; // R11
			bmapOn = split ? next_cur.region : rif.modeShadow[MODE_BMAP_BIT]; // R17
			// Character half of a split is always standard character
			mcOn = rif.modeShadow[MODE_MC_BIT] & (~split | next_cur.region); // R10
			next_cur.vert = rif.vertCur; // R12
			next_cur.vert[VERT_BMAP_BIT] = bmapOn; // R3
			next_cur.horz = rif.horzCur; // R12
			next_cur.horz[HORZ_MC_BIT] = mcOn; // R1
			// Upper nibble screen matrix, lower nibble data base
			next_cur.mem = bmapOn ? rif.bitmapPtr : rif.textPtr; // R4 R5 R6 R7 R8 R9 R16
			next_cur.load = 1'b1; // R18
			next_cur.count = cur.count + 8'h01;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign rif.load = cur.load;
	assign rif.vertNew = cur.vert;
	assign rif.horzNew = cur.horz;
	assign rif.memNew = cur.mem;
	assign rif.region = cur.region;
	assign rif.count = cur.count;
endmodule // vsr_refresh

/* logic/vsr_refresh_if.sv */
/*
 * Carrier between the register bank and the refresh engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface vsr_refresh_if;
	logic       trigger;
	logic [7:0] modeShadow;
	logic [7:0] textPtr;
	logic [7:0] bitmapPtr;
	logic [7:0] vertCur;
	logic [7:0] horzCur;
	logic       load;
	logic [7:0] vertNew;
	logic [7:0] horzNew;
	logic [7:0] memNew;
	logic       region;
	logic [7:0] count;

	modport bank
	(
		output trigger, modeShadow, textPtr, bitmapPtr, vertCur, horzCur,
		input  load, vertNew, horzNew, memNew, region, count
	);
	modport engine
	(
		input  trigger, modeShadow, textPtr, bitmapPtr, vertCur, horzCur,
		output load, vertNew, horzNew, memNew, region, count
	);
endinterface

/* logic/vsr_top.sv */
/*
 * Video shadow register refresh: APB register bank, raster interrupt sync and refresh.
 * Assumes an APB master on mclk and a raster interrupt pin asynchronous to mclk.
 */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module vsr_top
	import vsr_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              rasterIrq,
	output logic [7:0]             vertCtrl,
	output logic [7:0]             horzCtrl,
	output logic [7:0]             memPtrs,
	output logic                   bitmapRegion
);
	//****************************************
	// State and helpers
	//****************************************
	typedef struct packed
	{
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic [7:0]  mode;
		logic [7:0]  textPtr;
		logic [7:0]  bmapPtr;
		logic [7:0]  vert;
		logic [7:0]  horz;
		logic [7:0]  mem;
	} vsr_bank_s;

	vsr_bank_s cur;
	vsr_bank_s next_cur;
	logic      irqPulse;

	vsr_refresh_if rif ();

	function automatic vsr_reg_e decode(input logic [ADDR_W-1:0] addr);
		logic [17:0] idx;
		idx = addr[ADDR_W-1:2];
		if (addr[1:0] != 2'b00)
			decode = REG_NONE;
		else if (idx == IDX_MODE)
			decode = REG_MODE;
		else if (idx == IDX_TEXT_PTR)
			decode = REG_TEXT;
		else if (idx == IDX_BMAP_PTR)
			decode = REG_BMAP;
		else if (idx == IDX_VERT_CTRL)
			decode = REG_VERT;
		else if (idx == IDX_HORZ_CTRL)
			decode = REG_HORZ;
		else if (idx == IDX_MEM_PTRS)
			decode = REG_MEM;
		else if (idx == IDX_STATUS)
			decode = REG_STATUS;
		else
			decode = REG_NONE;
	endfunction

	//****************************************
	// Submodules
	//****************************************
	vsr_irq_sync u_sync
	(
		.mclk     (mclk),
		.rst_n    (rst_n),
		.irqPin   (rasterIrq),
		.irqPulse (irqPulse)
	);

	vsr_refresh u_refresh
	(
		.mclk  (mclk),
		.rst_n (rst_n),
		.rif   (rif.engine)
	);

	assign rif.trigger = irqPulse;
	assign rif.modeShadow = cur.mode;
	assign rif.textPtr = cur.textPtr;
	assign rif.bitmapPtr = cur.bmapPtr;
	assign rif.vertCur = cur.vert;
	assign rif.horzCur = cur.horz;

	//****************************************
	// APB slave and register bank
	//****************************************
	always_comb
	begin
		vsr_reg_e sel;
		logic     access;
		logic     wr;
		sel = decode(paddr);
		access = psel & penable & ~cur.pready;
		wr = access & pwrite & pstrb[0] & (sel != REG_NONE);
		next_cur = cur;
		next_cur.pready = access;
		next_cur.pslverr = access & (sel == REG_NONE);
		if (access && !pwrite)
		begin
			case (sel)
				REG_MODE:   next_cur.prdata = {24'h000000, cur.mode};
				REG_TEXT:   next_cur.prdata = {24'h000000, cur.textPtr};
				REG_BMAP:   next_cur.prdata = {24'h000000, cur.bmapPtr};
				REG_VERT:   next_cur.prdata = {24'h000000, cur.vert};
				REG_HORZ:   next_cur.prdata = {24'h000000, cur.horz};
				REG_MEM:    next_cur.prdata = {24'h000000, cur.mem};
				REG_STATUS: next_cur.prdata = {16'h0000, rif.count, 6'h00,
					cur.mode != MODE_DISABLE, rif.region};
				default:    next_cur.prdata = 32'h00000000;
			endcase
		end
		if (wr)
		begin
			case (sel)
				REG_MODE: next_cur.mode = pwdata[7:0];
				REG_TEXT: next_cur.textPtr = pwdata[7:0];
				REG_BMAP: next_cur.bmapPtr = pwdata[7:0];
				REG_VERT: next_cur.vert = pwdata[7:0];
				REG_HORZ: next_cur.horz = pwdata[7:0];
				REG_MEM:  next_cur.mem = pwdata[7:0];
				default:  next_cur.mode = cur.mode;
			endcase
		end
		// Refresh overrides a direct write landing in the same cycle
		if (rif.load) // R14 R18
		begin
			next_cur.vert = rif.vertNew;
			next_cur.horz = rif.horzNew;
			next_cur.mem = rif.memNew;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cur <= '0;
			cur.mode <= RST_MODE;
			cur.textPtr <= RST_TEXT_PTR;
			cur.bmapPtr <= RST_BMAP_PTR;
			cur.vert <= RST_VIDEO;
			cur.horz <= RST_VIDEO;
			cur.mem <= RST_VIDEO;
		end
		else
			cur <= next_cur;
	end

	assign pready = cur.pready;
	assign prdata = cur.prdata;
	assign pslverr = cur.pslverr;
	assign vertCtrl = cur.vert;
	assign horzCtrl = cur.horz;
	assign memPtrs = cur.mem;
	assign bitmapRegion = rif.region;

	//****************************************
	// Assertions
	//****************************************
	refresh_disabled_a: assert property (@(posedge mclk) disable iff (!rst_n) // R13
		irqPulse && cur.mode == MODE_DISABLE |=> !rif.load
		##1 ($stable(memPtrs) || $past(psel && penable && pwrite)))
		else $error("refresh ran while disabled");

	refresh_fires_a: assert property (@(posedge mclk) disable iff (!rst_n) // R12
		irqPulse && cur.mode != MODE_DISABLE |=> rif.load)
		else $error("interrupt did not start a refresh");

	mc_copy_a: assert property (@(posedge mclk) disable iff (!rst_n) // R1
		rif.load && !$past(cur.mode[MODE_SPLIT_BIT])
		|=> horzCtrl[HORZ_MC_BIT] == $past(cur.mode[MODE_MC_BIT], 2))
		else $error("multicolor bit not copied");

	bmap_copy_a: assert property (@(posedge mclk) disable iff (!rst_n) // R3
		rif.load && !$past(cur.mode[MODE_SPLIT_BIT])
		|=> vertCtrl[VERT_BMAP_BIT] == $past(cur.mode[MODE_BMAP_BIT], 2))
		else $error("bitmap bit not copied");

	text_ptr_a: assert property (@(posedge mclk) disable iff (!rst_n) // R8
		rif.load && !rif.vertNew[VERT_BMAP_BIT] |-> rif.memNew == $past(cur.textPtr))
		else $error("text pointer not used in character mode");

	bmap_ptr_a: assert property (@(posedge mclk) disable iff (!rst_n) // R9
		rif.load && rif.vertNew[VERT_BMAP_BIT] |-> rif.memNew == $past(cur.bmapPtr))
		else $error("bitmap pointer not used in bitmap mode");

	split_toggle_a: assert property (@(posedge mclk) disable iff (!rst_n) // R11
		rif.load && $past(cur.mode[MODE_SPLIT_BIT]) |-> rif.region != $past(rif.region)
		&& rif.vertNew[VERT_BMAP_BIT] == rif.region)
		else $error("split screen did not switch region");

	split_char_a: assert property (@(posedge mclk) disable iff (!rst_n) // R10
		rif.load && $past(cur.mode[MODE_SPLIT_BIT]) && !rif.region
		|-> !rif.horzNew[HORZ_MC_BIT])
		else $error("character half of split not standard");

	atomic_load_a: assert property (@(posedge mclk) disable iff (!rst_n) // R18
		rif.load |=> memPtrs == $past(rif.memNew) && vertCtrl == $past(rif.vertNew)
		&& horzCtrl == $past(rif.horzNew))
		else $error("mirrored fields not updated together");

	apb_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("apb answer not a single cycle");

	irq_single_a: assert property (@(posedge mclk) disable iff (!rst_n) // R11
		irqPulse |=> !irqPulse)
		else $error("interrupt pulse longer than one cycle");

	plain_region_a: assert property (@(posedge mclk) disable iff (!rst_n) // R17
		rif.load && !$past(cur.mode[MODE_SPLIT_BIT]) |-> !rif.region
		&& rif.vertNew[VERT_BMAP_BIT] == $past(cur.mode[MODE_BMAP_BIT]))
		else $error("region not cleared outside split screen");

	strobe_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		psel && penable && !pready && pwrite && !pstrb[0]
		|=> $stable(cur.mode) && $stable(cur.textPtr) && $stable(cur.bmapPtr))
		else $error("write without strobe changed a shadow");

	bad_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
		psel && penable && !pready && decode(paddr) == REG_NONE |=> pslverr)
		else $error("unmapped access not flagged");
endmodule // vsr_top

/* test/tb_video_shadow_register_refresh.sv */
/*
 * Self-checking bench for the shadow register refresh block.
 * Assumes the APB slave answers with pready and refresh lands within 14 cycles.
 */
`timescale 1ns/1ps
module tb_video_shadow_register_refresh;
	import vsr_pkg::*;
	typedef struct packed
	{
		logic [7:0] mode, text, bmap, vert, horz, mem;
		logic       rgn;
	} vsr_row_s;

	logic              mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic              rasterIrq, fire, bitmapRegion;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [3:0]        pstrb;
	logic [7:0]        vertCtrl, horzCtrl, memPtrs;
	int                nFail, totalChecks;
	vsr_row_s          rows [9] = '{
		'{8'h00, 8'h16, 8'h78, 8'h9b, 8'hc8, 8'h16, 1'b0},
		'{8'ha0, 8'h16, 8'h78, 8'hbb, 8'hd8, 8'h78, 1'b0},
		'{8'h80, 8'h16, 8'h78, 8'h9b, 8'hd8, 8'h16, 1'b0},
		'{8'h20, 8'h16, 8'h78, 8'hbb, 8'hc8, 8'h78, 1'b0},
		'{8'h40, 8'h16, 8'h78, 8'hbb, 8'hc8, 8'h78, 1'b1},
		'{8'h40, 8'h16, 8'h78, 8'h9b, 8'hc8, 8'h16, 1'b0},
		'{8'hc0, 8'h16, 8'h78, 8'hbb, 8'hd8, 8'h78, 1'b1},
		'{8'hc0, 8'h16, 8'h78, 8'h9b, 8'hc8, 8'h16, 1'b0},
		'{8'hff, 8'h25, 8'h78, 8'h9b, 8'hc8, 8'h00, 1'b0}};

	always #5 mclk = ~mclk;

	vsr_top vsr_top_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .rasterIrq(rasterIrq), .vertCtrl(vertCtrl),
		.horzCtrl(horzCtrl), .memPtrs(memPtrs), .bitmapRegion(bitmapRegion));
	vsr_host_model vsr_host_model_inst (.mclk(mclk), .rst_n(rst_n), .fire(fire),
		.rasterIrq(rasterIrq));

	task finishTest;
		$display("checks %0d errors %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			nFail++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [17:0] idx, input logic [31:0] d);
		int i;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++)
			@(posedge mclk);
		if (pready !== 1'b1)
		begin
			nFail++;
			finishTest();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task refresh;
		@(posedge mclk);
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (14) @(posedge mclk);
	endtask

	function automatic logic [31:0] outs();
		return {vertCtrl, horzCtrl, memPtrs, 7'h0, bitmapRegion};
	endfunction

	// ****************************************
	// Stimulus
	// ****************************************
	initial
	begin
		mclk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
		pwdata = '0; pstrb = 4'hf; fire = 0; nFail = 0; totalChecks = 0;
		repeat (2) @(posedge mclk);
		chk(outs(), 32'h0);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		apb(1'b0, IDX_MODE, 32'h0);
		chk(rd, {24'h0, RST_MODE});
		foreach (rows[k])
		begin
			apb(1'b1, IDX_MODE, {24'h0, rows[k].mode});
			apb(1'b1, IDX_TEXT_PTR, {24'h0, rows[k].text});
			apb(1'b1, IDX_BMAP_PTR, {24'h0, rows[k].bmap});
			apb(1'b1, IDX_VERT_CTRL, 32'h9b);
			apb(1'b1, IDX_HORZ_CTRL, 32'hc8);
			apb(1'b1, IDX_MEM_PTRS, 32'h0);
			refresh();
			chk(outs(), {rows[k].vert, rows[k].horz, rows[k].mem, 7'h0, rows[k].rgn});
		end
		apb(1'b0, IDX_TEXT_PTR, 32'h0);
		chk(rd, 32'h25);
		apb(1'b0, IDX_STATUS, 32'h0);
		chk(rd, 32'h00000800);
		apb(1'b0, 18'h00001, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		// Mid-run reset, then a strobe-less write of the disable value
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(outs(), 32'h0);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		pstrb <= 4'h0;
		apb(1'b1, IDX_MODE, 32'hff);
		pstrb <= 4'hf;
		apb(1'b1, IDX_TEXT_PTR, 32'h3c);
		refresh();
		chk(outs(), {8'h00, 8'h00, 8'h3c, 8'h00});
		apb(1'b0, IDX_STATUS, 32'h0);
		chk(rd, 32'h00000102);
		finishTest();
	end
endmodule // tb_video_shadow_register_refresh

/* test/vsr_host_model.sv */
/*
 * Host-side partner: raises the raster interrupt pin once per request.
 * Assumes fire is a one-cycle request from the bench on mclk.
 */
`timescale 1ns/1ps
module vsr_host_model
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic fire,
	output logic      rasterIrq
);
	logic [2:0] cnt;

	// Pin high four cycles then low, so each request gives one clean edge
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cnt       <= 3'h0;
			rasterIrq <= 1'b0;
		end
		else if (fire)
		begin
			cnt       <= 3'h4;
			rasterIrq <= 1'b1;
		end
		else if (cnt != 3'h0)
		begin
			cnt       <= cnt - 3'h1;
			rasterIrq <= (cnt != 3'h1);
		end
	end
endmodule // vsr_host_model
